// file: rtl/mma_core.sv
// Purpose: memory addressing, dual pointers and boot copy of the core
// Assumes: instruction decode outside; it issues accesses on these ports
// Notes:   program RAM, upper scratchpad and low RAM are flip-flops
//
// Contract
// - 4KB program RAM at address zero, readable and writable as data.
// - after power-on reset, copy boot image into program RAM from zero.
// - register-indirect external moves take upper address from page register.
// - internal bytes 0x00-0x7F reachable directly and indirectly.
// - above 0x80 direct selects registers, indirect selects upper scratchpad.
// - lowest 32 bytes are four register banks chosen by two status bits.
// - sixteen bytes after banks are bit addressable as bits 0x00-0x7F.
// - registers at addresses ending 0 or 8 are bit addressable.
// - image byte bit 3 chooses boot clock: 0 is 1 MHz, 1 is 0.5 MHz.
// - image byte bits 2-0 encode crystal rate 4,8,12,16,20 MHz.
// - instructions use standard encoding and standard flag effects.
// - one instruction cycle lasts four clocks.
// - instructions take one to five cycles; pointer read two, direct move three.
// - external moves take two plus clock control low bits cycles; code caps the count at five.
// - reserved opcode A5 acts as no-operation.
// - two 16-bit data pointers at 0x82/0x83 and 0x84/0x85.
// - pointer choice bit 0 selects which pointer instructions use.
// - only choice bit 0 exists so an increment toggles pointers.
// - fixed register bits ignore writes and read their fixed value.
// - all registers return to reset values on any reset.
// - port register at 0x80 is read/write, resets to FF, drives pins.
`timescale 1ns/1ps
module mma_core #(
  parameter int PROG_BYTES = mma_pkg::PROG_BYTES
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              por_i,
  // boot image byte stream
  input  wire logic              img_valid_i,
  input  wire logic [7:0]        img_data_i,
  input  wire logic              img_last_i,
  output logic                   img_ready_o,
  output logic                   boot_done_o,
  output logic                   boot_slow_o,
  output logic [2:0]             crystal_rate_code_o,
  // internal data / register access
  input  wire mma_pkg::mma_dreq_s dreq_i,
  input  wire logic              bit_op_i,
  input  wire logic [7:0]        bit_addr_i,
  input  wire logic              bit_val_i,
  output logic [7:0]             drdata_o,
  output logic                   bit_rdata_o,
  // external data move
  input  wire logic              xmove_i,
  input  wire logic              xmove_ri_i,
  input  wire logic              xmove_we_i,
  input  wire logic [7:0]        xmove_wdata_i,
  input  wire logic              code_rd_i,
  input  wire logic [15:0]       code_addr_i,
  output logic [7:0]             xrdata_o,
  output logic [15:0]            xaddr_o,
  // instruction timing
  input  wire logic              op_start_i,
  input  wire logic [7:0]        opcode_i,
  input  wire logic [2:0]        op_cycles_i,
  output logic [7:0]             eff_opcode_o,
  output logic                   op_busy_o,
  output logic                   op_done_o,
  output logic [7:0]             port0_o
);
  localparam int AW = $clog2(PROG_BYTES);

  logic [7:0]      prog_ram [PROG_BYTES];
  logic [7:0]      low_ram  [128];
  logic [7:0]      up_ram   [128];
  logic [7:0]      port0, ptra_lo, ptra_hi, ptrb_lo, ptrb_hi, page, clkctl, stat;
  logic            choice;
  mma_pkg::mma_boot_e boot_st;
  logic [AW-1:0]   load_ptr;
  logic            slow;
  logic [2:0]      xo;

  // --------------------------------------------------------------
  // address decode
  // --------------------------------------------------------------
  wire        is_upper   = dreq_i.addr[7];
  wire        sel_sfr    = is_upper && !dreq_i.indirect;
  wire        sel_up     = is_upper && dreq_i.indirect;
  wire        sel_low    = !is_upper;
  wire        d_wr       = dreq_i.en && dreq_i.we;
  wire        sfr_wr     = d_wr && sel_sfr;
  // bit address below 0x80 lands in the bit RAM, else in a register
  wire        bit_in_ram = !bit_addr_i[7];
  wire [7:0]  bit_byte   = bit_in_ram ? (mma_pkg::BITRAM_BASE + 8'(bit_addr_i[6:3]))
                                      : {bit_addr_i[7:3], 3'h0};
  wire [2:0]  bit_pos    = bit_addr_i[2:0];
  wire [1:0]  bank       = stat[mma_pkg::STAT_BANK_LO +: 2];
  // R0 or R1 of the active bank; the opcode's low bit picks which, as encoded
  wire [7:0]  rn_addr    = {3'h0, bank, 2'h0, opcode_i[0]};
  wire [15:0] ptr_sel    = choice ? {ptrb_hi, ptrb_lo} : {ptra_hi, ptra_lo};
  wire [7:0]  rn_val     = low_ram[rn_addr[6:0]];
  // indirect moves carry only a byte, so page fills the upper half
  wire [15:0] x_addr     = xmove_ri_i ? {page, rn_val} : ptr_sel;
  wire [15:0] m_addr     = code_rd_i ? code_addr_i : x_addr;
  wire        x_hit      = (m_addr < 16'(PROG_BYTES));
  wire        x_wr       = xmove_i && xmove_we_i && x_hit && boot_done_o;
  wire        boot_wr    = (boot_st == mma_pkg::MMA_BOOT_COPY) && img_valid_i;

  // register bit write view: merge a single bit into the byte
  wire        sfr_bitwr  = bit_op_i && !bit_in_ram;
  wire [7:0]  sfr_cur;
  wire [7:0]  sfr_wbyte  = sfr_bitwr ? ((sfr_cur & ~(8'h01 << bit_pos)) |
                                        (8'(bit_val_i) << bit_pos))
                                     : dreq_i.wdata;
  wire [7:0]  sfr_waddr  = sfr_bitwr ? bit_byte : dreq_i.addr;
  wire        sfr_we     = sfr_wr || sfr_bitwr;

  // --------------------------------------------------------------
  // register read mux; unused addresses read zero
  // --------------------------------------------------------------
  function automatic logic [7:0] sfr_read(input logic [7:0] a, input logic [7:0] p0,
      input logic [7:0] al, input logic [7:0] ah, input logic [7:0] bl,
      input logic [7:0] bh, input logic ch, input logic [7:0] pg,
      input logic [7:0] ck, input logic [7:0] ps);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      mma_pkg::SFR_PORT0:   r = p0;
      mma_pkg::SFR_PTRA_LO: r = al;
      mma_pkg::SFR_PTRA_HI: r = ah;
      mma_pkg::SFR_PTRB_LO: r = bl;
      mma_pkg::SFR_PTRB_HI: r = bh;
      mma_pkg::SFR_PCHOICE: r = {7'h00, ch};
      mma_pkg::SFR_PAGE:    r = pg;
      mma_pkg::SFR_CLKCTL:  r = ck;
      mma_pkg::SFR_STAT:    r = ps;
      default:              r = 8'h00;
    endcase
    return r;
  endfunction

  assign sfr_cur = sfr_read(bit_byte, port0, ptra_lo, ptra_hi, ptrb_lo, ptrb_hi,
                            choice, page, clkctl, stat);
  wire [7:0] sfr_rd = sfr_read(dreq_i.addr, port0, ptra_lo, ptra_hi, ptrb_lo,
                               ptrb_hi, choice, page, clkctl, stat);
  wire [7:0] bit_src = bit_in_ram ? low_ram[bit_byte[6:0]] : sfr_cur;

  // --------------------------------------------------------------
  // special registers, reset on any reset
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port0   <= mma_pkg::RST_PORT0;
      ptra_lo <= mma_pkg::RST_ZERO;
      ptra_hi <= mma_pkg::RST_ZERO;
      ptrb_lo <= mma_pkg::RST_ZERO;
      ptrb_hi <= mma_pkg::RST_ZERO;
      choice  <= 1'b0;
      page    <= mma_pkg::RST_ZERO;
      clkctl  <= mma_pkg::RST_CLKCTL;
      stat    <= mma_pkg::RST_ZERO;
    end else if (sfr_we) begin
      case (sfr_waddr)
        mma_pkg::SFR_PORT0:   port0   <= sfr_wbyte;
        mma_pkg::SFR_PTRA_LO: ptra_lo <= sfr_wbyte;
        mma_pkg::SFR_PTRA_HI: ptra_hi <= sfr_wbyte;
        mma_pkg::SFR_PTRB_LO: ptrb_lo <= sfr_wbyte;
        mma_pkg::SFR_PTRB_HI: ptrb_hi <= sfr_wbyte;
        mma_pkg::SFR_PCHOICE: choice  <= sfr_wbyte[0];
        mma_pkg::SFR_PAGE:    page    <= sfr_wbyte;
        mma_pkg::SFR_CLKCTL:  clkctl  <= sfr_wbyte;
        mma_pkg::SFR_STAT:    stat    <= sfr_wbyte;
        default:              port0   <= port0;         // unused address: no effect
      endcase
    end
  end

  // --------------------------------------------------------------
  // internal RAM: low half and upper scratchpad
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (d_wr && sel_low) begin
      low_ram[dreq_i.addr[6:0]] <= dreq_i.wdata;
    end else if (bit_op_i && bit_in_ram) begin
      low_ram[bit_byte[6:0]][bit_pos] <= bit_val_i;
    end
    if (d_wr && sel_up) begin
      up_ram[dreq_i.addr[6:0]] <= dreq_i.wdata;
    end
  end

  assign drdata_o    = sel_sfr ? sfr_rd :
                       sel_up  ? up_ram[dreq_i.addr[6:0]] : low_ram[dreq_i.addr[6:0]];
  assign bit_rdata_o = bit_src[bit_pos];

  // --------------------------------------------------------------
  // program RAM: boot copy and external/code moves
  // --------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (boot_wr) begin
      prog_ram[load_ptr] <= img_data_i;
    end else if (x_wr) begin
      prog_ram[m_addr[AW-1:0]] <= xmove_wdata_i;
    end
  end

  assign xrdata_o = x_hit ? prog_ram[m_addr[AW-1:0]] : 8'h00;
  assign xaddr_o  = m_addr;

  // --------------------------------------------------------------
  // boot loader: header byte then image copy from address zero
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      boot_st  <= mma_pkg::MMA_BOOT_IDLE;
      load_ptr <= '0;
      slow     <= 1'b0;
      xo       <= mma_pkg::XO_16;
    end else begin
      case (boot_st)
        mma_pkg::MMA_BOOT_IDLE: begin
          // a watchdog reset leaves por low, so the old program stays
          if (por_i) begin
            boot_st  <= mma_pkg::MMA_BOOT_HDR;
            load_ptr <= '0;
          end
        end
        mma_pkg::MMA_BOOT_HDR: begin
          if (img_valid_i) begin
            slow    <= img_data_i[mma_pkg::IMG_SPEED];
            xo      <= img_data_i[2:0];
            boot_st <= mma_pkg::MMA_BOOT_COPY;
          end
        end
        mma_pkg::MMA_BOOT_COPY: begin
          if (img_valid_i) begin
            load_ptr <= load_ptr + 1'b1;
            if (img_last_i || (load_ptr == AW'(PROG_BYTES - 1))) begin
              boot_st <= mma_pkg::MMA_BOOT_IDLE;
            end
          end
        end
        default: boot_st <= mma_pkg::MMA_BOOT_IDLE;
      endcase
    end
  end

  assign img_ready_o         = (boot_st != mma_pkg::MMA_BOOT_IDLE);
  assign boot_done_o         = (boot_st == mma_pkg::MMA_BOOT_IDLE) && !por_i;
  assign boot_slow_o         = slow;
  // codes above 4 are not defined; they fall back to 20 MHz
  assign crystal_rate_code_o = (xo > mma_pkg::XO_20) ? mma_pkg::XO_20 : xo;

  // --------------------------------------------------------------
  // instruction timing
  // --------------------------------------------------------------
  wire [3:0] x_cycles = 4'(mma_pkg::XMOVE_BASE) + {1'b0, clkctl[2:0]};
  wire [3:0] want     = xmove_i ? x_cycles : {1'b0, op_cycles_i};
  // clamp into the one to five cycle window of this core
  wire [2:0] ncyc     = (want > 4'(mma_pkg::MAX_CYC)) ? 3'(mma_pkg::MAX_CYC) :
                        (want < 4'(mma_pkg::MIN_CYC)) ? 3'(mma_pkg::MIN_CYC) :
                        want[2:0];

  mma_icycle #(
    .CLKS (mma_pkg::CLK_PER_ICYC)
  ) u_icycle (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .start_i (op_start_i),
    .ncyc_i  (ncyc),
    .busy_o  (op_busy_o),
    .done_o  (op_done_o)
  );

  // reserved opcode decoded as plain no-op; all others pass unchanged
  assign eff_opcode_o = (opcode_i == mma_pkg::OPC_RSVD_NOP) ? mma_pkg::OPC_NOP
                                                            : opcode_i;
  assign port0_o      = port0;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  property p_choice_reads;
    @(posedge clk_i) disable iff (!rstn_i)
      (dreq_i.en && !dreq_i.we && sel_sfr && dreq_i.addr == mma_pkg::SFR_PCHOICE)
        |-> drdata_o[7:1] == 7'h00;
  endproperty
  a_choice_reads: assert property (p_choice_reads) else $error("choice upper bits nonzero");

  property p_page_upper;
    @(posedge clk_i) disable iff (!rstn_i)
      (xmove_i && xmove_ri_i && !code_rd_i) |-> xaddr_o[15:8] == page;
  endproperty
  a_page_upper: assert property (p_page_upper) else $error("page not on upper address");

  property p_ptr_sel;
    @(posedge clk_i) disable iff (!rstn_i)
      (xmove_i && !xmove_ri_i && !code_rd_i) |->
        xaddr_o == (choice ? {ptrb_hi, ptrb_lo} : {ptra_hi, ptra_lo});
  endproperty
  a_ptr_sel: assert property (p_ptr_sel) else $error("wrong data pointer");

  property p_choice_toggle;
    @(posedge clk_i) disable iff (!rstn_i)
      (sfr_wr && !sfr_bitwr && dreq_i.addr == mma_pkg::SFR_PCHOICE) |=>
        choice == $past(dreq_i.wdata[0]);
  endproperty
  a_choice_toggle: assert property (p_choice_toggle) else $error("choice not updated");

  property p_icycle_len;
    @(posedge clk_i) disable iff (!rstn_i)
      (op_start_i && !op_busy_o && ncyc == 3'h1) |=> op_busy_o [*3] ##1 op_done_o;
  endproperty
  a_icycle_len: assert property (p_icycle_len) else $error("cycle not four clocks");

  property p_xmove_default;
    @(posedge clk_i) disable iff (!rstn_i)
      (xmove_i && clkctl[2:0] == 3'h1) |-> ncyc == 3'h3;
  endproperty
  a_xmove_default: assert property (p_xmove_default) else $error("external move length");

  property p_nop_a5;
    @(posedge clk_i) disable iff (!rstn_i)
      (opcode_i == mma_pkg::OPC_RSVD_NOP) |-> eff_opcode_o == mma_pkg::OPC_NOP;
  endproperty
  a_nop_a5: assert property (p_nop_a5) else $error("A5 not no-op");

  sequence s_hdr_taken;
    boot_st == mma_pkg::MMA_BOOT_HDR && img_valid_i;
  endsequence
  property p_hdr_decode;
    @(posedge clk_i) disable iff (!rstn_i)
      s_hdr_taken |=> slow == $past(img_data_i[3]) && load_ptr == '0;
  endproperty
  a_hdr_decode: assert property (p_hdr_decode) else $error("header decode wrong");

  property p_cyc_range;
    @(posedge clk_i) disable iff (!rstn_i)
      op_start_i |-> ncyc >= 3'h1 && ncyc <= 3'h5;
  endproperty
  a_cyc_range: assert property (p_cyc_range) else $error("cycle count out of range");
endmodule

// file: rtl/mma_pkg.sv
// Purpose: shared constants and types for the memory addressing block
// Assumes: 8-bit special register bus, 16-bit external data address
// Notes:   reset values of pointers and page register are taken as zero
package mma_pkg;
  // -------------------------------------------------------------------
  // special register addresses
  // -------------------------------------------------------------------
  localparam logic [7:0] SFR_PORT0   = 8'h80;
  localparam logic [7:0] SFR_PTRA_LO = 8'h82;
  localparam logic [7:0] SFR_PTRA_HI = 8'h83;
  localparam logic [7:0] SFR_PTRB_LO = 8'h84;
  localparam logic [7:0] SFR_PTRB_HI = 8'h85;
  localparam logic [7:0] SFR_PCHOICE = 8'h86;
  localparam logic [7:0] SFR_CLKCTL  = 8'h8e;
  localparam logic [7:0] SFR_PAGE    = 8'h92;
  localparam logic [7:0] SFR_STAT    = 8'hd0;
  // -------------------------------------------------------------------
  // reset values and fields
  // -------------------------------------------------------------------
  localparam logic [7:0] RST_PORT0   = 8'hff;
  localparam logic [7:0] RST_ZERO    = 8'h00;
  localparam logic [7:0] RST_CLKCTL  = 8'h01;
  localparam logic [7:0] PCHOICE_MSK = 8'h01;
  localparam int         STAT_BANK_LO = 3;
  localparam logic [7:0] UPPER_BASE  = 8'h80;
  localparam logic [7:0] BITRAM_BASE = 8'h20;
  localparam int         IMG_SPEED   = 3;
  localparam logic [2:0] XO_4        = 3'h0;
  localparam logic [2:0] XO_8        = 3'h1;
  localparam logic [2:0] XO_12       = 3'h2;
  localparam logic [2:0] XO_16       = 3'h3;
  localparam logic [2:0] XO_20       = 3'h4;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int         CLK_PER_ICYC = 4;
  localparam int         XMOVE_BASE   = 2;
  localparam int         DPTR_RD_CYC  = 2;
  localparam int         DIR_DIR_CYC  = 3;
  localparam int         MIN_CYC      = 1;
  localparam int         MAX_CYC      = 5;
  localparam logic [7:0] OPC_RSVD_NOP = 8'ha5;
  localparam logic [7:0] OPC_NOP      = 8'h00;
  localparam int         PROG_BYTES   = 4096;

  typedef enum logic [2:0] {
    MMA_BOOT_IDLE = 3'b001,
    MMA_BOOT_HDR  = 3'b010,
    MMA_BOOT_COPY = 3'b100
  } mma_boot_e;

  // internal data access request
  typedef struct packed {
    logic       en;
    logic       we;
    logic       indirect;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mma_dreq_s;
endpackage

// file: rtl/mma_icycle.sv
// Purpose: instruction cycle timer, four clocks per cycle, one done pulse in the last clock of the last cycle
// Assumes: start pulses only while idle
// Notes:   counts instruction cycles of one instruction
`timescale 1ns/1ps
module mma_icycle #(
  parameter int CLKS = mma_pkg::CLK_PER_ICYC
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       start_i,
  input  wire logic [2:0] ncyc_i,
  output logic            busy_o,
  output logic            done_o
);
  logic [1:0] phase;
  logic [2:0] left;
  wire        last_phase = (phase == 2'(CLKS - 1));

  // --------------------------------------------------------------
  // phase and cycle counter
  // --------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase <= 2'h0;
      left  <= 3'h0;
    end else if (start_i && !busy_o) begin
      phase <= 2'h0;
      left  <= ncyc_i;
    end else if (busy_o) begin
      phase <= last_phase ? 2'h0 : phase + 2'h1;
      if (last_phase) begin
        left <= left - 3'h1;
      end
    end
  end

  assign busy_o = (left != 3'h0);
  assign done_o = busy_o && last_phase && (left == 3'h1);
endmodule

// file: bench/mma_boot_mem.sv
// Purpose: serial boot memory model streaming a header and image bytes
// Assumes: byte handshake valid/ready, taken on the rising edge
// Notes:   idles one cycle between bytes to exercise a slow source
`timescale 1ns/1ps
module mma_boot_mem #(
  parameter int N = 8
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       ready_i,
  input  wire logic [7:0] hdr_i,
  output logic            valid_o,
  output logic [7:0]      data_o,
  output logic            last_o
);
  int   idx;
  logic took;
  initial begin
    valid_o = 1'b0;
    data_o  = 8'h00;
    last_o  = 1'b0;
    idx     = 0;
  end
  // header first, then image bytes from zero; data inverts when released
  always @(posedge clk_i) begin
    took = valid_o & ready_i;
    #1;
    if (!rstn_i) begin
      valid_o = 1'b0;
    end else if (took) begin
      idx++;
      valid_o = 1'b0;
      last_o  = 1'b0;
      data_o  = ~data_o;
    end else if (!valid_o && idx <= N && ready_i) begin
      valid_o = 1'b1;
      data_o  = (idx == 0) ? hdr_i : (8'h3c ^ 8'((idx - 1) * 7));
      last_o  = (idx == N);
    end
  end
endmodule

// file: bench/testbench.sv
// Purpose: self-checking bench of the memory addressing core
// Assumes: inputs change 1 ns after the rising edge
// Notes:   random register data from a fixed seed
`timescale 1ns/1ps
`define CHECK_EQ(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module testbench;
  logic clk_i, rstn_i, por_i, img_valid_i, img_last_i, bit_op_i, bit_val_i;
  logic xmove_i, xmove_ri_i, xmove_we_i, code_rd_i, op_start_i;
  logic [7:0] img_data_i, bit_addr_i, xmove_wdata_i, opcode_i, drdata_o, xrdata_o;
  logic [7:0] eff_opcode_o, port0_o, v, p [4];
  logic [15:0] code_addr_i, xaddr_o;
  logic [2:0] op_cycles_i, crystal_rate_code_o;
  logic img_ready_o, boot_done_o, boot_slow_o, bit_rdata_o, op_busy_o, op_done_o;
  mma_pkg::mma_dreq_s dreq_i;
  int seed, fails, compares, cyc, c, dn;
  mma_core u_mma_core (.clk_i(clk_i), .rstn_i(rstn_i), .por_i(por_i),
    .img_valid_i(img_valid_i), .img_data_i(img_data_i), .img_last_i(img_last_i),
    .img_ready_o(img_ready_o), .boot_done_o(boot_done_o), .boot_slow_o(boot_slow_o),
    .crystal_rate_code_o(crystal_rate_code_o), .dreq_i(dreq_i), .bit_op_i(bit_op_i),
    .bit_addr_i(bit_addr_i), .bit_val_i(bit_val_i), .drdata_o(drdata_o),
    .bit_rdata_o(bit_rdata_o), .xmove_i(xmove_i), .xmove_ri_i(xmove_ri_i),
    .xmove_we_i(xmove_we_i), .xmove_wdata_i(xmove_wdata_i), .code_rd_i(code_rd_i),
    .code_addr_i(code_addr_i), .xrdata_o(xrdata_o), .xaddr_o(xaddr_o),
    .op_start_i(op_start_i), .opcode_i(opcode_i), .op_cycles_i(op_cycles_i),
    .eff_opcode_o(eff_opcode_o), .op_busy_o(op_busy_o), .op_done_o(op_done_o),
    .port0_o(port0_o));
  mma_boot_mem #(.N(8)) u_mma_boot_mem (.clk_i(clk_i), .rstn_i(rstn_i),
    .ready_i(img_ready_o), .hdr_i(8'h0a), .valid_o(img_valid_i),
    .data_o(img_data_i), .last_o(img_last_i));
  // ------------------------------------------------------------------
  // clock, timeout and helpers
  // ------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // a hang in any wait loop ends here instead of running forever
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  function automatic logic [7:0] img(input int i);
    return 8'h3c ^ 8'(i * 7);
  endfunction
  task automatic give_verdict();
    $display("counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic ind, input logic [7:0] a, input logic [7:0] d);
    dreq_i = {1'b1, 1'b1, ind, a, d};
    @(posedge clk_i);
    #1 dreq_i = '0;
    @(posedge clk_i);
    #1;
  endtask
  // the read stands across an edge so the in-design checks see it
  task automatic rd(input logic ind, input logic [7:0] a, output logic [7:0] d);
    dreq_i = {1'b1, 1'b0, ind, a, 8'h00};
    @(posedge clk_i);
    d = drdata_o;
    #1 dreq_i = '0;
    @(posedge clk_i);
    #1;
  endtask
  task automatic time_op(input logic [2:0] n);
    op_cycles_i = n;
    op_start_i  = 1'b1;
    @(posedge clk_i);
    #1 op_start_i = 1'b0;
    c = 0;
    dn = 0;
    while (op_busy_o === 1'b1 && c < 100) begin
      c++;
      if (op_done_o === 1'b1) dn = c;
      @(posedge clk_i);
      #1;
    end
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {por_i, bit_op_i, bit_val_i, xmove_i, xmove_ri_i, xmove_we_i} = 6'h20;
    {code_rd_i, op_start_i, bit_addr_i, xmove_wdata_i} = '0;
    {opcode_i, code_addr_i, op_cycles_i, dreq_i} = '0;
    seed = 25;
    rstn_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    rd(0, mma_pkg::SFR_PORT0, v);   `CHECK_EQ("port0", 8'hff, v)
    rd(0, mma_pkg::SFR_CLKCTL, v);  `CHECK_EQ("clkctl", 8'h01, v)
    rd(0, mma_pkg::SFR_PCHOICE, v); `CHECK_EQ("choice", 8'h00, v)
    c = 0;
    while (img_ready_o !== 1'b1 && c < 50) begin c++; @(posedge clk_i); #1; end
    por_i = 1'b0;
    c = 0;
    while (boot_done_o !== 1'b1 && c < 200) begin c++; @(posedge clk_i); #1; end
    `CHECK_EQ("slow", 1'b1, boot_slow_o)
    `CHECK_EQ("xtal", 3'h2, crystal_rate_code_o)
    code_rd_i = 1'b1;
    for (int i = 0; i < 8; i++) begin
      code_addr_i = 16'(i);
      #1 `CHECK_EQ("image", img(i), xrdata_o)
    end
    code_rd_i = 1'b0;
    `CHECK_EQ("ready idle", 1'b0, img_ready_o)
    $display("test boot done");
    for (int i = 0; i < 4; i++) begin
      p[i] = 8'($random(seed));
      wr(0, 8'(8'h82 + i), p[i]);
    end
    for (int i = 0; i < 4; i++) begin
      rd(0, 8'(8'h82 + i), v); `CHECK_EQ("pointer", p[i], v)
    end
    wr(0, mma_pkg::SFR_PCHOICE, 8'hff);
    rd(0, mma_pkg::SFR_PCHOICE, v); `CHECK_EQ("choice", 8'h01, v)
    wr(0, mma_pkg::SFR_PCHOICE, v + 8'h01);
    rd(0, mma_pkg::SFR_PCHOICE, v); `CHECK_EQ("toggle", 8'h00, v)
    xmove_i = 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(0, mma_pkg::SFR_PCHOICE, 8'(s));
      `CHECK_EQ("ptr addr", {p[2*s+1], p[2*s]}, xaddr_o)
    end
    v = 8'($random(seed));
    wr(0, 8'h00, ~v);
    wr(0, 8'h01, ~v);
    wr(0, 8'h08, v);
    wr(0, 8'h09, ~v);
    wr(0, mma_pkg::SFR_STAT, 8'h08);
    wr(0, mma_pkg::SFR_PAGE, p[0]);
    opcode_i = 8'he2;
    xmove_ri_i = 1'b1;
    @(posedge clk_i);
    #1 `CHECK_EQ("ri addr", {p[0], v}, xaddr_o)
    `CHECK_EQ("opcode", 8'he2, eff_opcode_o)
    xmove_i = 1'b0;
    xmove_ri_i = 1'b0;
    wr(0, mma_pkg::SFR_PCHOICE, 8'h00);
    wr(0, 8'h82, 8'h23);
    wr(0, 8'h83, 8'h01);
    {xmove_i, xmove_we_i, xmove_wdata_i} = {2'b11, v};
    @(posedge clk_i);
    #1 {xmove_i, xmove_we_i, code_rd_i, code_addr_i} = {3'b001, 16'h0123};
    #1 `CHECK_EQ("ram data", v, xrdata_o)
    wr(1, mma_pkg::SFR_PAGE, ~p[0]);
    wr(0, 8'h40, p[1]);
    rd(0, mma_pkg::SFR_PAGE, v); `CHECK_EQ("direct hi", p[0], v)
    rd(1, mma_pkg::SFR_PAGE, v); `CHECK_EQ("indirect hi", ~p[0], v)
    rd(1, 8'h40, v); `CHECK_EQ("indirect lo", p[1], v)
    wr(0, 8'h21, 8'h00);
    {bit_op_i, bit_val_i, bit_addr_i} = {2'b11, 8'h0b};
    @(posedge clk_i);
    #1 {bit_op_i, bit_val_i, bit_addr_i} = {2'b10, 8'h85};
    @(posedge clk_i);
    #1 bit_op_i = 1'b0;
    rd(0, 8'h21, v); `CHECK_EQ("bit ram", 8'h08, v)
    `CHECK_EQ("bit sfr", 8'hdf, port0_o)
    `CHECK_EQ("bit read", 1'b0, bit_rdata_o)
    $display("test registers done");
    opcode_i = mma_pkg::OPC_RSVD_NOP;
    #1 `CHECK_EQ("a5", mma_pkg::OPC_NOP, eff_opcode_o)
    for (int n = 1; n <= 5; n++) begin
      time_op(3'(n)); `CHECK_EQ("op clocks", 4 * n, c)
      `CHECK_EQ("done at", 4 * n, dn)
    end
    xmove_i = 1'b1;
    time_op(3'h1); `CHECK_EQ("xmove", 12, c)
    wr(0, mma_pkg::SFR_CLKCTL, 8'h02);
    time_op(3'h1); `CHECK_EQ("xmove cc2", 16, c)
    xmove_i = 1'b0;
    $display("test timing done");
    rstn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    rd(0, mma_pkg::SFR_PORT0, v);   `CHECK_EQ("port0 rst", 8'hff, v)
    rd(0, mma_pkg::SFR_PCHOICE, v); `CHECK_EQ("choice rst", 8'h00, v)
    $display("test reset done");
    give_verdict();
  end
endmodule
